// File: design/cca_params.svh
/*
  Constants for the counter array: register offsets, field positions, reset
  values and divider counts. Assumes a 10 MHz system clock.
*/
`ifndef CCA_PARAMS_SVH
`define CCA_PARAMS_SVH

// Word offsets on the register bus (byte address = 4 * offset)
`define CCA_OFF_COUNT_LOW   5'h00
`define CCA_OFF_COUNT_HIGH  5'h01
`define CCA_OFF_MODE        5'h02
`define CCA_OFF_IRQ_EN      5'h03
`define CCA_OFF_STATUS      5'h04
`define CCA_OFF_IMASK       5'h05
`define CCA_OFF_MOD_MODE    5'h08
`define CCA_OFF_MOD_LOW     5'h09
`define CCA_OFF_MOD_HIGH    5'h0A
`define CCA_MOD_STRIDE      3

// array_mode_register fields
`define CCA_MD_ECF          0
`define CCA_MD_TB_LO        1
`define CCA_MD_WDT          5
`define CCA_MD_IDLE_HALT_CONTROL         7
`define CCA_MD_RESET        8'h20

// module_mode_register fields
`define CCA_MM_ECCF         0
`define CCA_MM_PWM          1
`define CCA_MM_TOG          2
`define CCA_MM_MAT          3
`define CCA_MM_FALLING_CAPTURE_SELECT         4
`define CCA_MM_RISING_CAPTURE_SELECT         5
`define CCA_MM_COMPARE_ENABLE         6
`define CCA_MM_WIDE_MODULATION_SELECT        7

// irq enable register: bit0 array, bit1 global
`define CCA_IE_ARRAY        0
`define CCA_IE_GLOBAL       1

// Status: bit0 overflow, bits 5:1 module flags
`define CCA_NUM_MOD         5
`define CCA_WDT_MOD         4

`define CCA_DIV12           4'hB
`define CCA_DIV4            4'h3
`define CCA_DIV8_TOGGLES    3'h7

`endif

// File: design/cca_pkg.sv
/*
  Types for the counter array: timebase codes and per-module modes.
  Assumes cca_params.svh holds all register and divider constants.
*/
package cca_pkg;

  typedef enum logic [2:0] {
    TB_DIV12  = 3'h0,
    TB_DIV4   = 3'h1,
    TB_T0OV   = 3'h2,
    TB_EXTPIN = 3'h3,
    TB_SYS    = 3'h4,
    TB_XOSC8  = 3'h5
  } timebase_t;

  typedef enum logic [6:0] {
    MM_IDLE    = 7'h01,
    MM_CAPTURE = 7'h02,
    MM_SWTIMER = 7'h04,
    MM_HSO     = 7'h08,
    MM_FREQ    = 7'h10,
    MM_PWM8    = 7'h20,
    MM_WIDE_MODULATION_SELECT   = 7'h40
  } mod_mode_t;

endpackage

// File: design/counter_array.sv
/*
  Counter array with a 16-bit timebase counter and five capture/compare
  modules, reached over Avalon-MM. Assumes pins and the external
  oscillator arrive asynchronously and are synchronised here.
*/
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`include "cca_params.svh"

module counter_array (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_cpu_idle,
  input  wire logic        i_timer0_overflow,
  input  wire logic        i_external_count_input,
  input  wire logic        i_ext_osc,
  input  wire logic [4:0]  i_module_io_line,
  output logic      [4:0]  o_module_io_line,
  output logic      [4:0]  o_module_io_line_oe,
  output logic             o_irq,
  output logic             o_cpu_irq
);

  localparam int NM = `CCA_NUM_MOD;

  typedef struct packed {
    logic [15:0]       cnt;
    logic [7:0]        snap;
    logic [7:0]        md;
    logic [1:0]        ien;
    logic [5:0]        stat;
    logic [5:0]        imask;
    logic [NM-1:0][7:0] mm;
    logic [NM-1:0][15:0] cp;
    logic [NM-1:0]     out;
    logic [NM-1:0]     oe;
    logic [NM-1:0][1:0] pin_s;
    logic [NM-1:0]     pin_prev;
    logic [1:0]        eci_s;
    logic              eci_prev;
    logic [1:0]        xo_s;
    logic              xo_prev;
    logic [2:0]        xo_div;
    logic [3:0]        pre;
    logic [31:0]       rdata;
    logic              ack;
    logic              irq;
    logic              cpu_irq;
  } state_t;

  state_t s_q, s_d;

  function automatic cca_pkg::mod_mode_t decode(input logic [7:0] m);
    logic compare_enable, rising_capture_select, falling_capture_select, match_enable, toggle_enable, pwm;
    compare_enable = m[`CCA_MM_COMPARE_ENABLE];
    rising_capture_select = m[`CCA_MM_RISING_CAPTURE_SELECT];
    falling_capture_select = m[`CCA_MM_FALLING_CAPTURE_SELECT];
    match_enable  = m[`CCA_MM_MAT];
    toggle_enable  = m[`CCA_MM_TOG];
    pwm  = m[`CCA_MM_PWM];
    decode = cca_pkg::MM_IDLE;
    if ((rising_capture_select | falling_capture_select) && !match_enable && !toggle_enable && !pwm) begin
      decode = cca_pkg::MM_CAPTURE;
    end else if (compare_enable && !rising_capture_select && !falling_capture_select && pwm && toggle_enable) begin
      decode = cca_pkg::MM_FREQ;
    end else if (compare_enable && !rising_capture_select && !falling_capture_select && pwm) begin
      decode = m[`CCA_MM_WIDE_MODULATION_SELECT] ? cca_pkg::MM_WIDE_MODULATION_SELECT : cca_pkg::MM_PWM8;
    end else if (compare_enable && !rising_capture_select && !falling_capture_select && match_enable) begin
      decode = toggle_enable ? cca_pkg::MM_HSO : cca_pkg::MM_SWTIMER;
    end
  endfunction

  logic              req_pending;
  logic              wr_take;
  logic              wdt_on;
  logic              tick;
  logic [2:0]        tb;
  logic [NM-1:0]     mod_flag;
  logic [NM-1:0]     pin_rise;
  logic [NM-1:0]     pin_fall;

  assign req_pending = (i_avs_read | i_avs_write) & ~s_q.ack;
  // Writes land only at the edge where the master sees waitrequest low
  assign wr_take     = i_avs_write & s_q.ack;
  assign wdt_on      = s_q.md[`CCA_MD_WDT];
  assign tb          = s_q.md[`CCA_MD_TB_LO +: 3];

  always_comb begin
    logic [15:0] cnt_next;
    logic        ovf;
    logic        run;
    logic [4:0]  idx;
    logic [5:0]  events;
    logic [5:0]  enables;
    cnt_next = 16'h0000;
    ovf      = 1'b0;
    run      = 1'b0;
    idx      = 5'h00;
    events   = 6'h00;
    enables  = 6'h00;
    s_d = s_q;

    // Input synchronisers: first stage feeds only the second
    s_d.eci_s    = {s_q.eci_s[0], i_external_count_input};
    s_d.eci_prev = s_q.eci_s[1];
    s_d.xo_s     = {s_q.xo_s[0], i_ext_osc};
    s_d.xo_prev  = s_q.xo_s[1];
    for (int n = 0; n < NM; n++) begin
      s_d.pin_s[n]    = {s_q.pin_s[n][0], i_module_io_line[n]};
      s_d.pin_prev[n] = s_q.pin_s[n][1];
    end

    // Prescaler runs freely; tick chosen below
    s_d.pre = (s_q.pre == `CCA_DIV12) ? 4'h0 : s_q.pre + 4'h1;
    if (s_q.xo_s[1] && !s_q.xo_prev) begin
      s_d.xo_div = s_q.xo_div + 3'h1;
    end

    // Watchdog forces counting on regardless of idle
    run = wdt_on || !(s_q.md[`CCA_MD_IDLE_HALT_CONTROL] && i_cpu_idle);
    cnt_next = s_q.cnt + 16'h0001;
    ovf = run && tick && (s_q.cnt == 16'hFFFF);
    if (run && tick) begin
      s_d.cnt = cnt_next;
    end

    // Module behaviour
    mod_flag = '0;
    for (int n = 0; n < NM; n++) begin
      case (decode(s_q.mm[n]))
        cca_pkg::MM_CAPTURE: begin
          if ((pin_rise[n] && s_q.mm[n][`CCA_MM_RISING_CAPTURE_SELECT]) ||
              (pin_fall[n] && s_q.mm[n][`CCA_MM_FALLING_CAPTURE_SELECT])) begin
            s_d.cp[n]   = s_q.cnt;
            mod_flag[n] = 1'b1;
          end
        end
        cca_pkg::MM_SWTIMER, cca_pkg::MM_HSO: begin
          if (run && tick && cnt_next == s_q.cp[n]) begin
            mod_flag[n] = 1'b1;
            if (s_q.mm[n][`CCA_MM_TOG]) begin
              s_d.out[n] = ~s_q.out[n];
            end
          end
        end
        cca_pkg::MM_FREQ: begin
          if (run && tick && cnt_next[7:0] == s_q.cp[n][7:0]) begin
            s_d.out[n]      = ~s_q.out[n];
            s_d.cp[n][7:0]  = s_q.cp[n][7:0] + s_q.cp[n][15:8];
          end
        end
        cca_pkg::MM_PWM8: begin
          if (run && tick) begin
            if (cnt_next[7:0] == 8'h00) begin
              s_d.out[n]     = 1'b0;
              s_d.cp[n][7:0] = s_q.cp[n][15:8];
            end
            if (cnt_next[7:0] == s_q.cp[n][7:0]) begin
              s_d.out[n] = 1'b1;
            end
          end
        end
        cca_pkg::MM_WIDE_MODULATION_SELECT: begin
          if (run && tick) begin
            if (cnt_next == 16'h0000) begin
              s_d.out[n] = 1'b0;
            end
            if (cnt_next == s_q.cp[n]) begin
              s_d.out[n]  = 1'b1;
              mod_flag[n] = s_q.mm[n][`CCA_MM_MAT];
            end
          end
        end
        default: begin
          s_d.out[n] = s_q.out[n];
        end
      endcase
    end

    // Bus: one wait cycle then acknowledge
    s_d.ack = req_pending;
    idx = i_avs_address;
    if (req_pending && i_avs_read) begin
      s_d.rdata = 32'h0000_0000;
      case (idx)
        `CCA_OFF_COUNT_LOW: begin
          s_d.rdata[7:0] = s_q.cnt[7:0];
          s_d.snap       = s_q.cnt[15:8];
        end
        `CCA_OFF_COUNT_HIGH: s_d.rdata[7:0] = s_q.snap;
        `CCA_OFF_MODE:       s_d.rdata[7:0] = s_q.md;
        `CCA_OFF_IRQ_EN:     s_d.rdata[1:0] = s_q.ien;
        `CCA_OFF_STATUS:     s_d.rdata[5:0] = s_q.stat;
        `CCA_OFF_IMASK:      s_d.rdata[5:0] = s_q.imask;
        default: begin
          for (int n = 0; n < NM; n++) begin
            if (idx == 5'(`CCA_OFF_MOD_MODE + `CCA_MOD_STRIDE * n)) begin
              s_d.rdata[7:0] = s_q.mm[n];
            end
            if (idx == 5'(`CCA_OFF_MOD_LOW + `CCA_MOD_STRIDE * n)) begin
              s_d.rdata[7:0] = s_q.cp[n][7:0];
            end
            if (idx == 5'(`CCA_OFF_MOD_HIGH + `CCA_MOD_STRIDE * n)) begin
              s_d.rdata[7:0] = s_q.cp[n][15:8];
            end
          end
        end
      endcase
    end

    // Flags: hardware set wins over write-one-to-clear
    events = {mod_flag, ovf};
    if (wr_take) begin
      case (idx)
        `CCA_OFF_COUNT_LOW: begin
          if (!wdt_on) s_d.cnt[7:0] = i_avs_writedata[7:0];
        end
        `CCA_OFF_COUNT_HIGH: begin
          if (!wdt_on) s_d.cnt[15:8] = i_avs_writedata[7:0];
        end
        `CCA_OFF_MODE: begin
          s_d.md[`CCA_MD_ECF] = i_avs_writedata[`CCA_MD_ECF];
          s_d.md[`CCA_MD_WDT] = i_avs_writedata[`CCA_MD_WDT];
          if (!wdt_on) begin
            s_d.md[`CCA_MD_TB_LO +: 3] = i_avs_writedata[`CCA_MD_TB_LO +: 3];
            s_d.md[`CCA_MD_IDLE_HALT_CONTROL]       = i_avs_writedata[`CCA_MD_IDLE_HALT_CONTROL];
          end
        end
        `CCA_OFF_IRQ_EN: s_d.ien   = i_avs_writedata[1:0];
        `CCA_OFF_STATUS: s_d.stat  = s_q.stat & ~i_avs_writedata[5:0];
        `CCA_OFF_IMASK:  s_d.imask = i_avs_writedata[5:0];
        default: begin
          for (int n = 0; n < NM; n++) begin
            if (idx == 5'(`CCA_OFF_MOD_MODE + `CCA_MOD_STRIDE * n) &&
                !(wdt_on && n == `CCA_WDT_MOD)) begin
              s_d.mm[n] = i_avs_writedata[7:0];
            end
            if (idx == 5'(`CCA_OFF_MOD_LOW + `CCA_MOD_STRIDE * n)) begin
              s_d.cp[n][7:0] = i_avs_writedata[7:0];
              s_d.mm[n][`CCA_MM_COMPARE_ENABLE] = 1'b0;
            end
            if (idx == 5'(`CCA_OFF_MOD_HIGH + `CCA_MOD_STRIDE * n)) begin
              s_d.cp[n][15:8] = i_avs_writedata[7:0];
              s_d.mm[n][`CCA_MM_COMPARE_ENABLE] = 1'b1;
            end
          end
        end
      endcase
    end
    s_d.stat = s_d.stat | events;

    // Line enables follow the next mode so they change with the mode write
    for (int n = 0; n < NM; n++) begin
      s_d.oe[n] = s_d.mm[n][`CCA_MM_TOG] || s_d.mm[n][`CCA_MM_PWM];
    end

    // Enables per source: overflow enable bit and module flag enables
    enables[0] = s_q.md[`CCA_MD_ECF];
    for (int n = 0; n < NM; n++) begin
      enables[n+1] = s_q.mm[n][`CCA_MM_ECCF];
    end
    s_d.irq     = |(s_q.stat & s_q.imask);
    s_d.cpu_irq = |(s_q.stat & enables) &&
                  s_q.ien[`CCA_IE_GLOBAL] && s_q.ien[`CCA_IE_ARRAY];
  end

  // Timebase selection
  always_comb begin
    case (tb)
      cca_pkg::TB_DIV12:  tick = (s_q.pre == `CCA_DIV12);
      cca_pkg::TB_DIV4:   tick = (s_q.pre[1:0] == 2'(`CCA_DIV4));
      cca_pkg::TB_T0OV:   tick = i_timer0_overflow;
      cca_pkg::TB_EXTPIN: tick = !s_q.eci_s[1] && s_q.eci_prev;
      cca_pkg::TB_SYS:    tick = 1'b1;
      cca_pkg::TB_XOSC8:  tick = s_q.xo_s[1] && !s_q.xo_prev &&
                                 (s_q.xo_div == `CCA_DIV8_TOGGLES);
      default:            tick = 1'b0;
    endcase
  end

  // Edge detection on synchronised module lines
  for (genvar g = 0; g < NM; g++) begin : g_edges
    assign pin_rise[g] = s_q.pin_s[g][1] && !s_q.pin_prev[g];
    assign pin_fall[g] = !s_q.pin_s[g][1] && s_q.pin_prev[g];
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s_q    <= '0;
      s_q.md <= `CCA_MD_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_avs_readdata      = s_q.rdata;
  assign o_avs_waitrequest   = ~s_q.ack;
  assign o_module_io_line    = s_q.out;
  assign o_module_io_line_oe = s_q.oe;
  assign o_irq               = s_q.irq;
  assign o_cpu_irq           = s_q.cpu_irq;

endmodule // counter_array

// File: tb/cca_monitor.sv
/* Port checker for counter_array.
   Assumes one synchronous reset and a bind to every counter_array. */
`timescale 1ns/1ps
module cca_monitor (
  input wire logic        i_clk,
  input wire logic        i_srst,
  input wire logic [4:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic [4:0]  o_module_io_line,
  input wire logic [4:0]  o_module_io_line_oe,
  input wire logic        o_irq,
  input wire logic        o_cpu_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  wire req = i_avs_read | i_avs_write;
  wire done = ~o_avs_waitrequest;
  property p_ans; req && o_avs_waitrequest |=> done; endproperty
  property p_one; done |=> o_avs_waitrequest; endproperty
  property p_req; done |-> $past(req); endproperty
  property p_rst;
    $past(i_srst) |-> o_avs_waitrequest && !o_irq && !o_cpu_irq && o_module_io_line == 5'h00;
  endproperty
  property p_hi0; done |-> o_avs_readdata[31:8] == 24'h000000; endproperty
  property p_unm;
    i_avs_read && done && i_avs_address inside {5'h06, 5'h07} |-> o_avs_readdata == 32'h0;
  endproperty
  // Read data must survive until the next read is answered
  property p_hold; !(i_avs_read && o_avs_waitrequest) |=> $stable(o_avs_readdata); endproperty
  property p_oe;
    i_avs_write && done && i_avs_address == 5'h08 |=>
      o_module_io_line_oe[0] == ($past(i_avs_writedata[2]) | $past(i_avs_writedata[1]));
  endproperty
  property p_oe_hold; !(i_avs_write && done) |=> $stable(o_module_io_line_oe); endproperty
  a_ans: assert property (p_ans) else $error("no answer one cycle after request");
  a_one: assert property (p_one) else $error("waitrequest low too long");
  a_req: assert property (p_req) else $error("answer without request");
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  a_hi0: assert property (p_hi0) else $error("upper read bits not zero");
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_oe: assert property (p_oe) else $error("line enable not following mode");
  a_oe_hold: assert property (p_oe_hold) else $error("line enable moved");
  c_read: cover property (i_avs_read && done);
  c_irq: cover property (o_irq);
  c_cpu: cover property (o_cpu_irq);
  c_oe: cover property (o_module_io_line_oe[0]);
endmodule // cca_monitor

bind counter_array cca_monitor mon (.i_clk, .i_srst, .i_avs_address, .i_avs_read,
  .i_avs_write, .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .o_module_io_line,
  .o_module_io_line_oe, .o_irq, .o_cpu_irq);

// File: tb/cpu_model.sv
/* Bus master standing in for the CPU core.
   Assumes Avalon-MM timing: request held until waitrequest is sampled low. */
`timescale 1ns/1ps
module cpu_model (
  input  wire logic        i_clk,
  input  wire logic        i_waitrequest,
  output logic      [4:0]  o_address,
  output logic             o_read,
  output logic             o_write,
  output logic      [31:0] o_writedata
);
  initial begin
    o_address = 5'h00;
    o_read = 1'b0;
    o_write = 1'b0;
    o_writedata = 32'h0;
  end
  task automatic xfer(input logic [4:0] a, input logic w, input logic [7:0] d);
    @(posedge i_clk);
    o_address <= a;
    o_read <= ~w;
    o_write <= w;
    o_writedata <= {24'h000000, d};
    do @(posedge i_clk); while (i_waitrequest !== 1'b0);
    o_read <= 1'b0;
    o_write <= 1'b0;
    // Released data is scrambled so nothing leans on a stale value
    o_writedata <= ~o_writedata;
  endtask
endmodule // cpu_model

// File: tb/tb.sv
/* Self-checking bench for counter_array.
   Assumes cpu_model drives the bus and the bound checker watches ports. */
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, srst = 1'b1, t0 = 1'b0, idle = 1'b0;
  logic [4:0] line = 5'h00;
  logic external_count_input = 1'b0, xosc = 1'b0;
  logic [4:0] adr;
  logic rd_s, wr_s, wreq, irq, cpu_irq;
  logic [31:0] wdat, rdat;
  logic [7:0] exp_q[$];
  logic [7:0] d;
  logic [7:0] caps[4] = '{8'h20, 8'h10, 8'h30, 8'h20};
  logic [7:0] modes[4] = '{8'h4C, 8'h46, 8'h42, 8'hC2};
  int failures = 0, cmp_count = 0, cyc = 0, i;
  integer seed = 63176;
  always #50 clk = ~clk;
  cpu_model cpu (.i_clk(clk), .i_waitrequest(wreq), .o_address(adr), .o_read(rd_s),
    .o_write(wr_s), .o_writedata(wdat));
  counter_array uut (.i_clk(clk), .i_srst(srst), .i_avs_address(adr), .i_avs_read(rd_s),
    .i_avs_write(wr_s), .i_avs_writedata(wdat), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq), .i_cpu_idle(idle), .i_timer0_overflow(t0),
    .i_external_count_input(external_count_input), .i_ext_osc(xosc), .i_module_io_line(line),
    .o_module_io_line(), .o_module_io_line_oe(), .o_irq(irq), .o_cpu_irq(cpu_irq));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input int a, input logic [7:0] v);
    cpu.xfer(5'(a), 1'b1, v);
  endtask
  task automatic rd(input int a, input logic [7:0] e);
    exp_q.push_back(e);
    cpu.xfer(5'(a), 1'b0, 8'h00);
  endtask
  task automatic pulse;
    @(posedge clk) t0 <= 1'b1;
    @(posedge clk) t0 <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic settle_chk(input logic seen_now, input logic e);
    repeat (3) @(posedge clk);
    chk(32'(irq & seen_now), 32'(e));
  endtask
  always @(posedge clk) begin
    if (rd_s === 1'b1 && wreq === 1'b0) chk(rdat, {24'h000000, exp_q.pop_front()});
    cyc++;
    if (cyc == 20000) begin
      failures++;
      test_done;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(4'h2, 8'h20);
    wr(20, 8'h42);
    rd(20, 8'h00);
    wr(4'h2, 8'h00);
    wr(4'h2, 8'h0C);
    wr(20, 8'h42);
    rd(20, 8'h42);
    wr(4'h0, 8'h00);
    wr(4'h2, 8'h08);
    wr(4'h2, 8'h0C);
    rd(4'h0, 8'h03);
    wr(4'h2, 8'h06);
    wr(4'h0, 8'h00);
    for (i = 0; i < 4; i++) begin
      repeat (4) @(posedge clk);
      external_count_input <= 1'b1;
      repeat (4) @(posedge clk);
      external_count_input <= 1'b0;
    end
    repeat (4) @(posedge clk);
    rd(4'h0, 8'h04);
    wr(4'h2, 8'h0A);
    wr(4'h0, 8'h00);
    for (i = 0; i < 16; i++) begin
      repeat (2) @(posedge clk);
      xosc <= 1'b1;
      repeat (2) @(posedge clk);
      xosc <= 1'b0;
    end
    repeat (4) @(posedge clk);
    rd(4'h0, 8'h02);
    wr(4'h2, 8'h0C);
    for (i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      wr(4'h0, d);
      rd(4'h0, d);
    end
    rd(4'h6, 8'h00);
    wr(4'h7, 8'h55);
    wr(4'h2, 8'h04);
    wr(4'h0, 8'hFF);
    wr(4'h1, 8'hFF);
    rd(4'h0, 8'hFF);
    pulse;
    rd(4'h1, 8'hFF);
    rd(4'h0, 8'h00);
    rd(4'h4, 8'h01);
    wr(4'h5, 8'h01);
    settle_chk(1'b1, 1'b1);
    wr(4'h3, 8'h01);
    wr(4'h2, 8'h05);
    repeat (3) @(posedge clk);
    chk(32'(cpu_irq), 32'h0);
    wr(4'h3, 8'h03);
    repeat (3) @(posedge clk);
    chk(32'(cpu_irq), 32'h1);
    rd(4'h4, 8'h01);
    wr(4'h4, 8'h01);
    settle_chk(1'b1, 1'b0);
    wr(4'h2, 8'h84);
    idle <= 1'b1;
    pulse;
    rd(4'h0, 8'h00);
    wr(4'h2, 8'h04);
    pulse;
    rd(4'h0, 8'h01);
    idle <= 1'b0;
    wr(4'h2, 8'h0C);
    wr(4'h0, 8'h5A);
    for (i = 0; i < 4; i++) begin
      wr(4'h8, caps[i]);
      line[0] <= ~line[0];
      repeat (6) @(posedge clk);
      rd(4'h4, (i < 3) ? 8'h02 : 8'h00);
      rd(4'h9, 8'h5A);
      wr(4'h4, 8'hFF);
    end
    wr(4'h8, 8'h48);
    wr(4'h9, 8'h10);
    rd(4'h8, 8'h08);
    wr(4'hA, 8'h00);
    rd(4'h8, 8'h48);
    for (i = 0; i < 4; i++) begin
      wr(4'h8, modes[i]);
      rd(4'h8, modes[i]);
    end
    repeat (3) @(posedge clk);
    test_done;
  end
endmodule // tb
